/* File: dscs_map.vh */
`ifndef DSCS_MAP_VH
`define DSCS_MAP_VH

// register indices; byte address is four times the index
`define DSCS_IDX_CONTROL_ONE  6'h20
`define DSCS_IDX_STATUS       6'h21
`define DSCS_IDX_TRACE_CTRL   6'h22
`define DSCS_IDX_TRACE_COUNT  6'h26
`define DSCS_IDX_SEQ_CTRL     6'h27
`define DSCS_IDX_WIN_BASE     3'h5

// debug_control_one fields
`define DSCS_C1_ARM           7
`define DSCS_C1_FORCE_TRIGGER          6
`define DSCS_C1_ROUTE         4
`define DSCS_C1_BRK           3
`define DSCS_C1_BANK_HI       1
`define DSCS_C1_BANK_LO       0

// trace_control fields
`define DSCS_TC_ENABLE        6
`define DSCS_TC_MODE_HI       3
`define DSCS_TC_MODE_LO       2
`define DSCS_TC_ALIGN         0

// comparator bank select values
`define DSCS_BANK_A           2'h0
`define DSCS_BANK_B           2'h1
`define DSCS_BANK_C           2'h2
`define DSCS_BANK_NONE        2'h3

// sequencer states
`define DSCS_ST_DISARMED      3'h0
`define DSCS_ST_ONE           3'h1
`define DSCS_ST_FINAL         3'h4

// reset values and the last line count
`define DSCS_RST_BYTE         8'h00
`define DSCS_RST_SEQ_CTRL     3'h0
`define DSCS_RST_COUNT        6'h00
`define DSCS_COUNT_LAST       6'h3f

`endif

/* File: dscs_seq.v */
`timescale 1ns/1ps
`include "dscs_map.vh"

module dscs_seq
(
	input  wire       clk_i,
	input  wire       ce_i,
	input  wire       rst_i,
	input  wire       armed_i,
	input  wire       arm_set_i,
	input  wire       force_final_i,
	input  wire       advance_i,
	input  wire [2:0] next_state_i,
	input  wire       end_internal_i,
	output reg  [2:0] state_o
);

	wire legal_next;

	// reserved encodings above final are never taken
	assign legal_next = (next_state_i <= `DSCS_ST_FINAL) && (next_state_i != `DSCS_ST_DISARMED);

	always @(posedge clk_i)
	begin
		if (rst_i)
			state_o <= `DSCS_ST_DISARMED;
		else if (ce_i)
		begin
			if (end_internal_i)
				state_o <= `DSCS_ST_DISARMED;
			else if (arm_set_i)
				state_o <= `DSCS_ST_ONE;
			else if (armed_i)
			begin
				if (force_final_i)
					state_o <= `DSCS_ST_FINAL;
				else if (advance_i && legal_next && (state_o != `DSCS_ST_FINAL))
					state_o <= next_state_i;
			end
			// software disarm leaves the last state in place
		end
	end

endmodule

/* File: dscs_top.v */
// What this block does
// - software sets/clears session enable; hardware clears it at trace end or untraced breakpoint
// - arming puts the sequencer in state one, flags read 001
// - writing 1 to force trigger requests a trigger; 0 ignored; reads 0
// - forced trigger jumps to final; breakpoint issued at trace completion per settings
// - with trace enable clear, no trigger starts recording
// - forced trigger ignored once begin-aligned recording has started
// - while secured, tracing disabled and force trigger cannot start tracing
// - control one bits 7,1,0 always writable; bits 4:3 only while disarmed
// - route bit picks background mode or software interrupt for breakpoints
// - breakpoint enable plus final state requests breakpoint, after tracing if traced
// - bank select picks comparator bank shown in the eight-byte window
// - banks 0..2 show comparators A..C and their sequencer control; 3 shows match flags
// - trace full set once 64 lines stored since the last arm write of 1
// - trace full cleared by arm write of 1 and power-on reset only
// - trace full also reads at bit 7 of the trace count register
// - state flags follow every sequencer transition, 000..100 encoding
// - software disarm keeps the last sequencer state
// - internally ended session returns sequencer and flags to zero
// - status register always readable, writes ignored
// - while armed only arm, force trigger and bank select are writable
`timescale 1ns/1ps
`include "dscs_map.vh"

module dscs_top
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        por_i,
	input  wire        ce_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output wire [31:0] dat_o,
	output reg         ack_o,
	input  wire        secured_i,
	input  wire        background_debug_enable_i,
	input  wire        background_active_i,
	input  wire        seq_advance_i,
	input  wire [2:0]  seq_next_state_i,
	input  wire        trace_line_stored_i,
	input  wire        trace_done_i,
	input  wire [2:0]  match_flags_i,
	input  wire [7:0]  cmp_rdata_i,
	output wire        cmp_wr_o,
	output wire [1:0]  cmp_bank_o,
	output wire [2:0]  cmp_addr_o,
	output wire [7:0]  cmp_wdata_o,
	output reg         session_armed_o,
	output reg         recording_o,
	output reg         trigger_o,
	output reg         bdm_entry_o,
	output reg         software_interrupt_request_o,
	output wire        trace_enable_o,
	output wire [1:0]  trace_mode_select_o,
	output wire        trigger_alignment_o,
	output wire [2:0]  sequencer_state_flags_o,
	output wire [2:0]  sequencer_control_one_o,
	output wire [2:0]  sequencer_control_two_o,
	output wire [2:0]  sequencer_control_three_o
);

	reg        route_sel;
	reg        brk_en;
	reg  [1:0] bank_sel;
	reg        trace_en;
	reg  [1:0] trace_mode;
	reg        align_begin;
	reg  [2:0] seq_ctrl_one;
	reg  [2:0] seq_ctrl_two;
	reg  [2:0] seq_ctrl_three;
	reg        brk_pending;
	reg        final_seen;
	reg        trace_full;
	reg  [5:0] line_count;
	reg  [7:0] rdata;
	reg  [7:0] next_rdata;

	wire       rst_any;
	wire       wb_req;
	wire       wb_wr;
	wire [5:0] idx;
	wire [7:0] wd;
	wire       in_window;
	wire       wr_c1;
	wire       wr_tc;
	wire       wr_sc;
	wire       arm_set;
	wire       arm_write_one;
	wire       sw_disarm;
	wire       force_final;
	wire       trace_on;
	wire [2:0] seq_state;
	wire       final_rise;
	wire       trace_end;
	wire       brk_now;
	wire       end_internal;
	wire       brk_fire;
	wire       line_in;

	// other system resets clear everything but the trace full flag
	assign rst_any = rst_i | por_i;

	assign wb_req    = cyc_i & stb_i;
	// writes land on the edge that ends the cycle, i.e. while ack is high
	assign wb_wr     = wb_req & we_i & ack_o & sel_i[0];
	assign idx       = adr_i[7:2];
	assign wd        = dat_i[7:0];
	assign in_window = (idx[5:3] == `DSCS_IDX_WIN_BASE);

	assign wr_c1 = wb_wr && (idx == `DSCS_IDX_CONTROL_ONE);
	assign wr_tc = wb_wr && (idx == `DSCS_IDX_TRACE_CTRL) && !session_armed_o;
	assign wr_sc = wb_wr && (idx == `DSCS_IDX_SEQ_CTRL) && !session_armed_o;

	assign arm_write_one = wr_c1 & wd[`DSCS_C1_ARM];
	assign arm_set       = arm_write_one & ~session_armed_o;
	assign sw_disarm     = wr_c1 & ~wd[`DSCS_C1_ARM] & session_armed_o;

	// tracing is inhibited while secured even if the enable bit was set earlier
	assign trace_on = trace_en & ~secured_i;

	// a forced trigger is dropped once begin-aligned recording runs
	assign force_final = wr_c1 & wd[`DSCS_C1_FORCE_TRIGGER] & session_armed_o & ~(recording_o & align_begin);

	assign final_rise = session_armed_o & (seq_state == `DSCS_ST_FINAL) & ~final_seen;
	assign trace_end  = session_armed_o & recording_o & trace_done_i;
	// untraced breakpoint fires at once and ends the session
	assign brk_now      = final_rise & brk_en & ~trace_on;
	assign end_internal = trace_end | brk_now;
	assign brk_fire     = brk_now | (trace_end & brk_pending);
	assign line_in      = trace_line_stored_i & recording_o;

	dscs_seq u_seq
	(
		.clk_i          (clk_i),
		.ce_i           (ce_i),
		.rst_i          (rst_any),
		.armed_i        (session_armed_o),
		.arm_set_i      (arm_set),
		.force_final_i  (force_final),
		.advance_i      (seq_advance_i),
		.next_state_i   (seq_next_state_i),
		.end_internal_i (end_internal),
		.state_o        (seq_state)
	);

	// session enable and the control one fields
	always @(posedge clk_i)
	begin
		if (rst_any)
		begin
			session_armed_o <= 1'b0;
			route_sel       <= 1'b0;
			brk_en          <= 1'b0;
			bank_sel        <= `DSCS_BANK_A;
		end
		else if (ce_i)
		begin
			if (end_internal)
				session_armed_o <= 1'b0;
			else if (wr_c1)
				session_armed_o <= wd[`DSCS_C1_ARM];
			if (wr_c1)
				bank_sel <= wd[`DSCS_C1_BANK_HI:`DSCS_C1_BANK_LO];
			// armed state before the write gates bits 4:3, so a disarming write keeps them
			if (wr_c1 && !session_armed_o)
			begin
				route_sel <= wd[`DSCS_C1_ROUTE];
				brk_en    <= wd[`DSCS_C1_BRK];
			end
		end
	end

	// trace control and sequencer control registers
	always @(posedge clk_i)
	begin
		if (rst_any)
		begin
			trace_en       <= 1'b0;
			trace_mode     <= 2'h0;
			align_begin    <= 1'b0;
			seq_ctrl_one   <= `DSCS_RST_SEQ_CTRL;
			seq_ctrl_two   <= `DSCS_RST_SEQ_CTRL;
			seq_ctrl_three <= `DSCS_RST_SEQ_CTRL;
		end
		else if (ce_i)
		begin
			if (wr_tc)
			begin
				if (!secured_i)
					trace_en <= wd[`DSCS_TC_ENABLE];
				trace_mode  <= wd[`DSCS_TC_MODE_HI:`DSCS_TC_MODE_LO];
				align_begin <= wd[`DSCS_TC_ALIGN];
			end
			if (wr_sc)
			begin
				case (bank_sel)
					`DSCS_BANK_A: seq_ctrl_one   <= wd[2:0];
					`DSCS_BANK_B: seq_ctrl_two   <= wd[2:0];
					`DSCS_BANK_C: seq_ctrl_three <= wd[2:0];
					default:      seq_ctrl_one   <= seq_ctrl_one;
				endcase
			end
		end
	end

	// recording, pending breakpoint and breakpoint routing
	always @(posedge clk_i)
	begin
		if (rst_any)
		begin
			recording_o                  <= 1'b0;
			brk_pending                  <= 1'b0;
			final_seen                   <= 1'b0;
			trigger_o                    <= 1'b0;
			bdm_entry_o                  <= 1'b0;
			software_interrupt_request_o <= 1'b0;
		end
		else if (ce_i)
		begin
			trigger_o <= final_rise;
			if (arm_set || end_internal || sw_disarm)
				final_seen <= 1'b0;
			else if (final_rise)
				final_seen <= 1'b1;

			if (end_internal || sw_disarm)
				recording_o <= 1'b0;
			else if (arm_set && trace_on && !align_begin)
				recording_o <= 1'b1;
			else if (final_rise && trace_on && align_begin)
				recording_o <= 1'b1;

			if (end_internal || sw_disarm || arm_set)
				brk_pending <= 1'b0;
			else if (final_rise && brk_en && trace_on)
				brk_pending <= 1'b1;

			bdm_entry_o                  <= brk_fire & route_sel & background_debug_enable_i;
			software_interrupt_request_o <= brk_fire & (route_sel ? ~background_debug_enable_i
			                                                      : ~background_active_i);
		end
	end

	// line count and trace full flag; only power-on and an arm write of 1 clear the flag
	always @(posedge clk_i)
	begin
		if (por_i)
			trace_full <= 1'b0;
		else if (ce_i)
		begin
			if (line_in && (line_count == `DSCS_COUNT_LAST))
				trace_full <= 1'b1;
			else if (arm_write_one)
				trace_full <= 1'b0;
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_any)
			line_count <= `DSCS_RST_COUNT;
		else if (ce_i)
		begin
			if (arm_write_one)
				line_count <= `DSCS_RST_COUNT;
			else if (line_in)
				line_count <= line_count + 6'h01;
		end
	end

	// read mux; status ignores writes as it has no write path
	always @*
	begin
		next_rdata = `DSCS_RST_BYTE;
		case (idx)
			`DSCS_IDX_CONTROL_ONE:
				next_rdata = {session_armed_o, 2'b00, route_sel, brk_en, 1'b0, bank_sel};
			`DSCS_IDX_STATUS:
				next_rdata = {trace_full, 4'h0, seq_state};
			`DSCS_IDX_TRACE_CTRL:
				next_rdata = {1'b0, trace_en, 2'b00, trace_mode, 1'b0, align_begin};
			`DSCS_IDX_TRACE_COUNT:
				next_rdata = {trace_full, 1'b0, line_count};
			`DSCS_IDX_SEQ_CTRL:
			begin
				case (bank_sel)
					`DSCS_BANK_A: next_rdata = {5'h00, seq_ctrl_one};
					`DSCS_BANK_B: next_rdata = {5'h00, seq_ctrl_two};
					`DSCS_BANK_C: next_rdata = {5'h00, seq_ctrl_three};
					default:      next_rdata = {5'h00, match_flags_i};
				endcase
			end
			default:
			begin
				if (in_window && (bank_sel != `DSCS_BANK_NONE))
					next_rdata = cmp_rdata_i;
				else
					next_rdata = `DSCS_RST_BYTE;
			end
		endcase
	end

	// one wait state: ack a cycle after the request, dropped the cycle after
	always @(posedge clk_i)
	begin
		if (rst_any)
		begin
			ack_o <= 1'b0;
			rdata <= `DSCS_RST_BYTE;
		end
		else if (ce_i)
		begin
			ack_o <= wb_req & ~ack_o;
			if (wb_req && !ack_o)
				rdata <= next_rdata;
		end
	end

	assign dat_o = {24'h000000, rdata};

	// comparator bank registers live outside; they accept writes only while disarmed
	assign cmp_wr_o    = wb_wr & in_window & ~session_armed_o & (bank_sel != `DSCS_BANK_NONE);
	assign cmp_bank_o  = bank_sel;
	assign cmp_addr_o  = adr_i[4:2];
	assign cmp_wdata_o = wd;

	assign trace_enable_o            = trace_on;
	assign trace_mode_select_o       = trace_mode;
	assign trigger_alignment_o       = align_begin;
	assign sequencer_state_flags_o   = seq_state;
	assign sequencer_control_one_o   = seq_ctrl_one;
	assign sequencer_control_two_o   = seq_ctrl_two;
	assign sequencer_control_three_o = seq_ctrl_three;

endmodule

/* File: dscs_properties.sv */
`timescale 1ns/1ps

module dscs_properties
(
	input wire        clk_i,
	input wire        rst_i,
	input wire        por_i,
	input wire        ce_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire        we_i,
	input wire [7:0]  adr_i,
	input wire [3:0]  sel_i,
	input wire [31:0] dat_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        secured_i,
	input wire        background_debug_enable_i,
	input wire        trace_done_i,
	input wire [1:0]  cmp_bank_o,
	input wire        cmp_wr_o,
	input wire        session_armed_o,
	input wire        recording_o,
	input wire        trigger_o,
	input wire        bdm_entry_o,
	input wire        software_interrupt_request_o,
	input wire        trace_enable_o,
	input wire        trigger_alignment_o,
	input wire [2:0]  sequencer_state_flags_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i || por_i);

	// the ack edge is the one at which a write takes effect
	sequence s_ctl_wr;
		ack_o && we_i && sel_i[0] && adr_i == 8'h80;
	endsequence

	sequence s_final_entry;
		sequencer_state_flags_o == 3'h4 && $past(sequencer_state_flags_o) != 3'h4;
	endsequence

	chk_ack_once: assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack not a single pulse after request");
	chk_arm_set: assert property (s_ctl_wr ##0 dat_i[7] |=> session_armed_o)
		else $error("session enable not set by write");
	chk_arm_state: assert property (s_ctl_wr ##0 (dat_i[7] && !session_armed_o) |=> ##[0:1] sequencer_state_flags_o == 3'h1)
		else $error("arming did not give state one");
	chk_disarm_keep: assert property (s_ctl_wr ##0 !dat_i[7] |=> !session_armed_o && $stable(sequencer_state_flags_o))
		else $error("software disarm lost state");
	chk_force_trigger_final: assert property (s_ctl_wr ##0 (dat_i[6] && session_armed_o
		&& !(recording_o && trigger_alignment_o)) |=> ##[0:1] sequencer_state_flags_o == 3'h4)
		else $error("forced trigger did not reach final");
	chk_force_trigger_pulse: assert property (s_final_entry |-> ##[0:1] trigger_o)
		else $error("no trigger after final entry");
	chk_force_trigger_reads0: assert property (ack_o && !we_i && adr_i == 8'h80 |-> dat_o[6] == 1'b0 && dat_o[31:8] == 24'h0)
		else $error("force trigger bit read back set");
	chk_done_end: assert property (trace_done_i && recording_o && session_armed_o
		|=> ##[0:1] (!session_armed_o && sequencer_state_flags_o == 3'h0))
		else $error("trace completion did not end session");
	// recording is launched from the previous edge, so only a rise after a secured edge counts
	chk_secure_trace: assert property (secured_i |-> !trace_enable_o && (!$past(secured_i) || !$rose(recording_o)))
		else $error("tracing while secured");
	chk_bp_route: assert property (bdm_entry_o |-> $past(background_debug_enable_i) && !software_interrupt_request_o)
		else $error("background entry misrouted");
	chk_win_write: assert property (cmp_wr_o |-> ack_o && we_i && cyc_i && adr_i[7:5] == 3'h5
		&& !session_armed_o && cmp_bank_o != 2'h3)
		else $error("window write at wrong time or bank");
endmodule

bind dscs_top dscs_properties chk (.*);

/* File: dscs_core_model.sv */
`timescale 1ns/1ps

module dscs_core_model
(
	input  wire       clk_i,
	input  wire       go_i,
	input  wire [6:0] lines_i,
	input  wire [1:0] bank_i,
	input  wire [2:0] addr_i,
	output logic      line_o,
	output logic      done_o,
	output wire [7:0] rdata_o
);
	int left = 0;

	// bank and slot folded into the data so a wrong selection shows in the value
	assign rdata_o = {1'b1, bank_i, 2'h0, addr_i};

	initial
	begin
		line_o = 1'b0;
		done_o = 1'b0;
	end

	// one line every other cycle, slower than the core could go, then completion
	always @(posedge clk_i)
	begin
		line_o <= left > 1 && left[0];
		done_o <= left == 1;
		if (go_i)
			left <= 2 * lines_i + 1;
		else if (left > 0)
			left <= left - 1;
	end
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps

module tb_top;
	logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, cyc_i = 1'b0, we_i = 1'b0;
	wire         ce_i = 1'b1;
	wire         stb_i = cyc_i;
	wire  [3:0]  sel_i = 4'h1;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, q;
	logic        secured_i = 1'b0, background_debug_enable_i = 1'b0, background_active_i = 1'b0;
	logic        seq_advance_i = 1'b0, go = 1'b0;
	logic [2:0]  seq_next_state_i = 3'h0, match_flags_i = 3'h0;
	logic [6:0]  lines = 7'h00;
	wire         trace_line_stored_i, trace_done_i, ack_o, cmp_wr_o, session_armed_o, recording_o;
	wire         trigger_o, bdm_entry_o, software_interrupt_request_o, trace_enable_o, trigger_alignment_o;
	wire  [7:0]  cmp_rdata_i, cmp_wdata_o;
	wire  [31:0] dat_o;
	wire  [1:0]  cmp_bank_o, trace_mode_select_o;
	wire  [2:0]  cmp_addr_o, sequencer_state_flags_o, sequencer_control_one_o;
	wire  [2:0]  sequencer_control_two_o, sequencer_control_three_o;
	int          mismatches = 0, checks = 0, nb = 0, ns = 0, nw = 0;

	dscs_top dut (.*);
	dscs_core_model far (.clk_i(clk_i), .go_i(go), .lines_i(lines), .bank_i(cmp_bank_o), .addr_i(cmp_addr_o),
		.line_o(trace_line_stored_i), .done_o(trace_done_i), .rdata_o(cmp_rdata_i));

	always #50 clk_i = ~clk_i;

	always @(posedge clk_i)
	begin
		nb += (bdm_entry_o === 1'b1);
		ns += (software_interrupt_request_o === 1'b1);
		nw += (cmp_wr_o === 1'b1 && cmp_wdata_o === 8'h55 && cmp_addr_o === 3'h2);
	end

	task chk(input logic [31:0] s, e);
		checks++;
		if (s !== e)
		begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// entered just after an edge; the request is held until ack is sampled
	task wb(input logic w, input logic [7:0] a, d);
		cyc_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task rd(input logic [7:0] a, e);
		wb(1'b0, a, 8'h00);
		chk(q, {24'h0, e});
	endtask

	task t_reset;
		rd(8'h80, 8'h00);
		rd(8'h84, 8'h00);
		rd(8'h88, 8'h00);
		rd(8'hfc, 8'h00);
		$display("reset test done");
	endtask

	task t_arm;
		wb(1'b1, 8'h80, 8'h9b);
		rd(8'h80, 8'h9b);
		rd(8'h84, 8'h01);
		wb(1'b1, 8'h84, 8'hff);
		rd(8'h84, 8'h01);
		wb(1'b1, 8'h80, 8'h80);
		rd(8'h80, 8'h98);
		wb(1'b1, 8'h88, 8'h41);
		rd(8'h88, 8'h00);
		// window write while armed must not reach the comparator bank
		wb(1'b1, 8'ha8, 8'h55);
		for (int s = 2; s < 4; s++)
		begin
			seq_next_state_i <= s[2:0];
			seq_advance_i <= 1'b1;
			@(posedge clk_i);
			seq_advance_i <= 1'b0;
			rd(8'h84, s[7:0]);
		end
		wb(1'b1, 8'h80, 8'h00);
		rd(8'h80, 8'h18);
		rd(8'h84, 8'h03);
		wb(1'b1, 8'h80, 8'h00);
		rd(8'h80, 8'h00);
		$display("arm test done");
	endtask

	task t_route;
		logic [7:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c = i < 2 ? 8'h18 : 8'h08;
			background_debug_enable_i <= i == 0;
			background_active_i <= i == 3;
			wb(1'b1, 8'h80, c | 8'h80);
			nb = 0;
			ns = 0;
			wb(1'b1, 8'h80, c | 8'hc0);
			repeat (6) @(posedge clk_i);
			chk(nb, i == 0);
			chk(ns, i == 1 || i == 2);
			if (i < 3)
			begin
				rd(8'h84, 8'h00);
				rd(8'h80, c);
			end
			wb(1'b1, 8'h80, 8'h00);
		end
		$display("route test done");
	endtask

	task t_secure;
		// enable set while open, so securing has something to inhibit
		wb(1'b1, 8'h88, 8'h40);
		secured_i <= 1'b1;
		wb(1'b1, 8'h88, 8'h00);
		rd(8'h88, 8'h40);
		chk(trace_enable_o, 1'b0);
		wb(1'b1, 8'h80, 8'h80);
		wb(1'b1, 8'h80, 8'hc0);
		rd(8'h84, 8'h04);
		chk(recording_o, 1'b0);
		wb(1'b1, 8'h80, 8'h00);
		rd(8'h84, 8'h04);
		secured_i <= 1'b0;
		wb(1'b1, 8'h88, 8'h00);
		$display("secure test done");
	endtask

	task t_bank;
		match_flags_i <= 3'h5;
		for (int b = 0; b < 4; b++)
		begin
			wb(1'b1, 8'h80, b[7:0]);
			wb(1'b1, 8'h9c, 8'h01 + b[7:0]);
			rd(8'h9c, b == 3 ? 8'h05 : 8'h01 + b[7:0]);
			wb(1'b1, 8'ha8, 8'h55);
			if (b < 3)
				rd(8'ha4, 8'h81 | (b[7:0] << 5));
		end
		chk({sequencer_control_three_o, sequencer_control_two_o, sequencer_control_one_o}, 9'h0d1);
		chk(nw, 3);
		$display("bank test done");
	endtask

	task t_trace;
		int n;
		n = 0;
		// begin-aligned session: recording starts only at final entry
		background_active_i <= 1'b0;
		wb(1'b1, 8'h88, 8'h4d);
		chk({trace_mode_select_o, trigger_alignment_o, trace_enable_o}, 4'hf);
		wb(1'b1, 8'h80, 8'h88);
		chk(recording_o, 1'b0);
		wb(1'b1, 8'h80, 8'hc0);
		rd(8'h84, 8'h04);
		chk(recording_o, 1'b1);
		ns = 0;
		lines <= 7'h01;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk(ns, 1);
		rd(8'h84, 8'h00);
		rd(8'h80, 8'h08);
		wb(1'b1, 8'h80, 8'h00);
		wb(1'b1, 8'h88, 8'h48);
		rd(8'h88, 8'h48);
		chk({trace_mode_select_o, trigger_alignment_o}, 3'h4);
		wb(1'b1, 8'h80, 8'h80);
		lines <= 7'h40;
		go <= 1'b1;
		@(posedge clk_i);
		go <= 1'b0;
		while (session_armed_o !== 1'b0 && n < 300)
		begin
			@(posedge clk_i);
			n++;
		end
		rd(8'h84, 8'h80);
		rd(8'h98, 8'h80);
		rd(8'h80, 8'h00);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(8'h84, 8'h80);
		wb(1'b1, 8'h80, 8'h80);
		rd(8'h84, 8'h01);
		$display("trace test done");
	endtask

	task close_out;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// some 80 bus cycles plus one 64-line session; ample margin
	initial
	begin
		#500000;
		mismatches++;
		close_out;
	end

	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		@(posedge clk_i);
		t_reset;
		t_arm;
		t_route;
		t_secure;
		t_bank;
		t_trace;
		close_out;
	end
endmodule
